// ==== rtl/irg_pkg.sv ====
// Constants for the initial reset generator.
// Assumes one 100 MHz clock; every hold is turned into a count of clock cycles.
package irg_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned PIN_HOLD_US     = 5_000;      // Reset pin least hold, us
  localparam int unsigned PORT_HOLD_MS    = 4_000;      // Port combination hold, ms
  localparam int unsigned PIN_HOLD_CYC    = (CLK_HZ / 1_000_000) * PIN_HOLD_US;
  localparam int unsigned PORT_HOLD_CYC   = (CLK_HZ / 1_000) * PORT_HOLD_MS;
  localparam int unsigned OSC_START_CYC   = 16;         // Reference clock cycles of run level seen before run
  localparam int unsigned SYNC_STAGES     = 2;
  localparam int unsigned CNT_W           = 32;
  localparam logic [7:0]  PC_STEP_INIT    = 8'h00;
  localparam logic [3:0]  PC_PAGE_INIT    = 4'h1;
  localparam logic [3:0]  NEW_PAGE_INIT   = 4'h1;
  typedef enum logic [1:0] {
    IRG_PORT_OFF,
    IRG_PORT_K01,
    IRG_PORT_K012,
    IRG_PORT_K0123
  } irg_port_sel_t;
endpackage

// ==== rtl/irg_filter.sv ====
// Noise rejection filter: output follows the input only after a sustained level.
// Assumes input is synchronous to clk; hold is a cycle count parameter.
`timescale 1ns/1ps
module irg_filter #(
  parameter int unsigned HOLD  = 16,
  parameter int unsigned CNT_W = 32
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic level_in,
  output logic      level_out
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             next_level;

  always_comb begin
    next_count = count;
    next_level = level_out;
    if (level_in == level_out) begin
      next_count = '0;
    end else if (count >= CNT_W'(HOLD - 1)) begin
      // Both edges need a sustained level, so short glitches never toggle it
      next_level = level_in;
      next_count = '0;
    end else begin
      next_count = count + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      count     <= '0;
      level_out <= 1'b0;
    end else begin
      count     <= next_count;
      level_out <= next_level;
    end
  end
endmodule

// ==== rtl/irg_top.sv ====
// Initial reset generator: merges oscillator-stop, reset pin and port-combination
// resets, holds the CPU start state and releases the CPU synchronously.
// Assumes all inputs synchronous to REF_CLK_IN; OSC_RUN_IN is a run level
// from the oscillator, PORT_SEL_IN is a fixed option strap.
// What this block does
// - Three independent reset sources: oscillator stop, reset pin, input port combination.
// - Reset is held while the oscillator is stopped until it runs.
// - A high level on the reset pin requests initial reset.
// - Reset pin passes a noise filter; short high pulses are ignored.
// - CPU stays halted while pin high, runs after pin returns low.
// - All selected input port pins high together cause initial reset.
// - Port option: off, pins 0-1, pins 0-2, or pins 0-3.
// - Reset loads step 00H, page 1H, new page 1H, clears I and D.
`timescale 1ns/1ps
module irg_top
  import irg_pkg::*;
#(
  parameter int unsigned PIN_HOLD  = irg_pkg::PIN_HOLD_CYC,
  parameter int unsigned PORT_HOLD = irg_pkg::PORT_HOLD_CYC
) (
  input  wire logic                   REF_CLK_IN,
  input  wire logic                   RESET_N_IN,
  input  wire logic                   OSC_RUN_IN,
  input  wire logic                   RESET_PIN_IN,
  input  wire logic [3:0]             INPUT_PORT_PINS_IN,
  input  wire irg_pkg::irg_port_sel_t PORT_SEL_IN,
  output logic                        CPU_RESET_OUT,
  output logic                        CPU_RUN_OUT,
  output logic [7:0]                  PROGRAM_COUNTER_STEP_OUT,
  output logic [3:0]                  PROGRAM_COUNTER_PAGE_OUT,
  output logic [3:0]                  NEW_PAGE_POINTER_OUT,
  output logic                        INTERRUPT_FLAG_OUT,
  output logic                        DECIMAL_FLAG_OUT
);
  import irg_pkg::*;

  typedef enum {IRG_HELD, IRG_RUN} irg_state_t;

  function automatic logic port_combo(input logic [3:0] pins, input irg_port_sel_t sel);
    logic r;
    r = 1'b0;
    case (sel)
      IRG_PORT_K01:   r = &pins[1:0];
      IRG_PORT_K012:  r = &pins[2:0];
      IRG_PORT_K0123: r = &pins[3:0];
      default:        r = 1'b0;
    endcase
    return r;
  endfunction

  logic       pin_filt;
  logic       port_filt;
  logic       port_raw;
  logic [4:0] osc_cnt;
  logic [4:0] next_osc_cnt;
  logic       osc_ok;
  logic       next_osc_ok;
  logic [SYNC_STAGES-1:0] rel_sync;
  logic [SYNC_STAGES-1:0] next_rel_sync;
  logic       any_src;
  irg_state_t state;
  irg_state_t next_state;
  logic       next_cpu_reset;
  logic       next_cpu_run;

  assign port_raw = port_combo(INPUT_PORT_PINS_IN, PORT_SEL_IN);

  irg_filter #(.HOLD(PIN_HOLD), .CNT_W(CNT_W)) u_pin_filt (
    .clk_in    (REF_CLK_IN),
    .rst_n_in  (RESET_N_IN),
    .level_in  (RESET_PIN_IN),
    .level_out (pin_filt)
  );

  irg_filter #(.HOLD(PORT_HOLD), .CNT_W(CNT_W)) u_port_filt (
    .clk_in    (REF_CLK_IN),
    .rst_n_in  (RESET_N_IN),
    .level_in  (port_raw),
    .level_out (port_filt)
  );

  // Oscillator counts as running only after a run of good cycles
  always_comb begin
    next_osc_cnt = osc_cnt;
    next_osc_ok  = osc_ok;
    if (!OSC_RUN_IN) begin
      next_osc_cnt = '0;
      next_osc_ok  = 1'b0;
    end else if (osc_cnt >= 5'(OSC_START_CYC - 1)) begin
      next_osc_ok = 1'b1;
    end else begin
      next_osc_cnt = osc_cnt + 5'd1;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      osc_cnt <= '0;
      osc_ok  <= 1'b0;
    end else begin
      osc_cnt <= next_osc_cnt;
      osc_ok  <= next_osc_ok;
    end
  end

  assign any_src = !osc_ok || pin_filt || port_filt;

  // Assert at once, release through a short synchroniser chain
  always_comb begin
    next_rel_sync = {rel_sync[SYNC_STAGES-2:0], 1'b1};
    if (any_src) begin
      next_rel_sync = '0;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      rel_sync <= '0;
    end else begin
      rel_sync <= next_rel_sync;
    end
  end

  always_comb begin
    next_state     = state;
    next_cpu_reset = CPU_RESET_OUT;
    next_cpu_run   = CPU_RUN_OUT;
    case (state)
      IRG_HELD: begin
        next_cpu_reset = 1'b1;
        next_cpu_run   = 1'b0;
        if (rel_sync[SYNC_STAGES-1] && !any_src) begin
          next_state     = IRG_RUN;
          next_cpu_reset = 1'b0;
          next_cpu_run   = 1'b1;
        end
      end
      IRG_RUN: begin
        if (any_src) begin
          next_state     = IRG_HELD;
          next_cpu_reset = 1'b1;
          next_cpu_run   = 1'b0;
        end
      end
      default: next_state = IRG_HELD;
    endcase
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      state         <= IRG_HELD;
      CPU_RESET_OUT <= 1'b1;
      CPU_RUN_OUT   <= 1'b0;
    end else begin
      state         <= next_state;
      CPU_RESET_OUT <= next_cpu_reset;
      CPU_RUN_OUT   <= next_cpu_run;
    end
  end

  // Start values are pinned at the reset values; the CPU loads them while held
  always_ff @(posedge REF_CLK_IN) begin
    PROGRAM_COUNTER_STEP_OUT <= PC_STEP_INIT;
    PROGRAM_COUNTER_PAGE_OUT <= PC_PAGE_INIT;
    NEW_PAGE_POINTER_OUT     <= NEW_PAGE_INIT;
    INTERRUPT_FLAG_OUT       <= 1'b0;
    DECIMAL_FLAG_OUT         <= 1'b0;
  end

  property p_osc_stop_holds;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      !OSC_RUN_IN |=> ##1 CPU_RESET_OUT;
  endproperty
  a_osc_stop_holds: assert property (p_osc_stop_holds) else $error("reset not held, osc stopped");

  property p_pin_holds;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      pin_filt |=> CPU_RESET_OUT;
  endproperty
  a_pin_holds: assert property (p_pin_holds) else $error("pin reset not holding cpu");

  property p_port_holds;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      port_filt |=> CPU_RESET_OUT;
  endproperty
  a_port_holds: assert property (p_port_holds) else $error("port reset not holding cpu");

  property p_run_excl;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      CPU_RUN_OUT != CPU_RESET_OUT;
  endproperty
  a_run_excl: assert property (p_run_excl) else $error("run and reset disagree");

  property p_sync_release;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      $fell(CPU_RESET_OUT) |-> $past(!any_src) && $past(rel_sync[SYNC_STAGES-1]);
  endproperty
  a_sync_release: assert property (p_sync_release) else $error("release not synchronised");

  property p_no_quick_release;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      $rose(CPU_RESET_OUT) |=> CPU_RESET_OUT [*2];
  endproperty
  a_no_quick_release: assert property (p_no_quick_release) else $error("reset too short");

  property p_glitch_ignored;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      (!pin_filt && $rose(RESET_PIN_IN)) ##1 !RESET_PIN_IN |-> !pin_filt;
  endproperty
  a_glitch_ignored: assert property (p_glitch_ignored) else $error("pin glitch accepted");

  property p_port_off;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      PORT_SEL_IN == IRG_PORT_OFF |-> !port_raw;
  endproperty
  a_port_off: assert property (p_port_off) else $error("disabled port option fired");

  property p_init_values;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      CPU_RESET_OUT |-> PROGRAM_COUNTER_PAGE_OUT == PC_PAGE_INIT && !INTERRUPT_FLAG_OUT;
  endproperty
  a_init_values: assert property (p_init_values) else $error("start values wrong");

  c_pin_reset:  cover property (@(posedge REF_CLK_IN) $rose(pin_filt));
  c_port_reset: cover property (@(posedge REF_CLK_IN) $rose(port_filt));
  c_run:        cover property (@(posedge REF_CLK_IN) $rose(CPU_RUN_OUT));
endmodule

// ==== dv/irg_ext_model.sv ====
// Model of the external reset circuit and the keys on the input port pins.
// Assumes the bench clock; drives its pins just after rising edges.
`timescale 1ns/1ps
module irg_ext_model (
  input  wire logic       clk_in,
  output logic            pin_out,
  output logic [3:0]      port_out
);
  // Pins idle low, since the port pins carry pull-downs
  initial begin
    pin_out  = 1'b0;
    port_out = 4'h0;
  end

  // Level on the reset pin held for n edges, then released
  task automatic press_pin(input int n);
    @(posedge clk_in);
    pin_out <= 1'b1;
    repeat (n) @(posedge clk_in);
    pin_out <= 1'b0;
  endtask

  // Key pattern held for n edges; callers hold past the filter time to be accepted
  task automatic press_port(input logic [3:0] keys, input int n);
    @(posedge clk_in);
    port_out <= keys;
    repeat (n) @(posedge clk_in);
    port_out <= 4'h0;
  endtask
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the initial reset generator.
// Assumes shortened filter holds; the oscillator start qualification stays as built.
`timescale 1ns/1ps
module testbench;
  import irg_pkg::*;
  localparam int PH = 8;
  localparam int QH = 12;
  logic          clk;
  logic          rst_n;
  logic          osc_run;
  logic          pin;
  logic [3:0]    port;
  irg_port_sel_t sel;
  logic          cpu_rst;
  logic          cpu_run;
  logic [7:0]    step;
  logic [3:0]    page;
  logic [3:0]    new_page_pointer;
  logic          iflag;
  logic          dflag;
  int            fails = 0;
  int            cmp_count = 0;

  irg_top #(.PIN_HOLD(PH), .PORT_HOLD(QH)) irg_top_inst (
    .REF_CLK_IN(clk), .RESET_N_IN(rst_n), .OSC_RUN_IN(osc_run), .RESET_PIN_IN(pin),
    .INPUT_PORT_PINS_IN(port), .PORT_SEL_IN(sel), .CPU_RESET_OUT(cpu_rst),
    .CPU_RUN_OUT(cpu_run), .PROGRAM_COUNTER_STEP_OUT(step),
    .PROGRAM_COUNTER_PAGE_OUT(page), .NEW_PAGE_POINTER_OUT(new_page_pointer),
    .INTERRUPT_FLAG_OUT(iflag), .DECIMAL_FLAG_OUT(dflag));
  irg_ext_model irg_ext_model_inst (.clk_in(clk), .pin_out(pin), .port_out(port));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_rst(input logic v, input int max, input string what);
    int n;
    n = 0;
    while (cpu_rst !== v && n < max) begin
      @(posedge clk); #1;
      n++;
    end
    check(what, {7'h0, v}, {7'h0, cpu_rst});
    check("cpu_run", {7'h0, ~v}, {7'h0, cpu_run});
  endtask

  // Stops at the first edge where the level slips so the check sees it
  task automatic stay_rst(input logic v, input int cyc, input string what);
    repeat (cyc) begin
      @(posedge clk); #1;
      if (cpu_rst !== v) break;
    end
    check(what, {7'h0, v}, {7'h0, cpu_rst});
  endtask

  task automatic t_osc;
    stay_rst(1'b1, 30, "osc_stopped_hold");
    @(posedge clk);
    osc_run <= 1'b1;
    wait_rst(1'b0, 40, "osc_start_release");
    check("pc_step", 8'h00, step);
    check("pc_page", 8'h01, {4'h0, page});
    check("new_page", 8'h01, {4'h0, new_page_pointer});
    check("flags", 8'h00, {6'h0, iflag, dflag});
    @(posedge clk);
    osc_run <= 1'b0;
    wait_rst(1'b1, 3, "osc_stop_reset");
    @(posedge clk);
    osc_run <= 1'b1;
    wait_rst(1'b0, 40, "osc_restart");
  endtask

  task automatic t_pin;
    // A pulse just short of the hold, then a one-cycle spike for the glitch assertion
    fork
      begin
        irg_ext_model_inst.press_pin(PH - 2);
        irg_ext_model_inst.press_pin(1);
      end
      stay_rst(1'b0, PH + 10, "pin_glitch");
    join
    fork
      irg_ext_model_inst.press_pin(40);
      begin
        wait_rst(1'b1, PH + 4, "pin_reset");
        stay_rst(1'b1, 25, "pin_held");
      end
    join
    wait_rst(1'b0, PH + 8, "pin_release");
  endtask

  // A missing key must not trip; the full set trips unless the option is off
  task automatic t_port(input int s, input logic [3:0] keys);
    @(posedge clk);
    sel <= irg_port_sel_t'(s);
    fork
      irg_ext_model_inst.press_port(keys & 4'he, QH + 8);
      stay_rst(1'b0, QH + 14, "port_partial");
    join
    fork
      irg_ext_model_inst.press_port(keys, QH + 8);
      if (s == 0) stay_rst(1'b0, QH + 14, "port_off");
      else wait_rst(1'b1, QH + 4, "port_reset");
    join
    wait_rst(1'b0, QH + 8, "port_release");
  endtask

  task automatic results;
    $display("Checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    osc_run = 1'b0;
    sel = IRG_PORT_OFF;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_osc();
    t_pin();
    t_port(0, 4'hf);
    t_port(1, 4'h3);
    t_port(2, 4'h7);
    t_port(3, 4'hf);
    results();
  end

  // Whole sequence needs well under 1000 cycles
  initial begin
    #100000;
    fails++;
    results();
  end
endmodule
